// ### bench/sram_ctrl_model.sv
// Purpose: Memory controller model that drives the burst SRAM pins
// Assumes: Requests start 1 ns after a rising edge; both beats of a cycle ride together
// Notes:   Released address, data and masks show the inverse of their last value
`timescale 1ns/1ps
module sram_ctrl_model
  import burst_sram_pkg::*;
(
  input  wire logic  core_clk,
  input  wire pair_s rdata,
  input  wire logic  rdata_oe,
  output logic       write_port_select_n,
  output logic       read_port_select_n,
  output addr_t      addr,
  output pair_s      wdata,
  output mask_pair_s byte_write_mask_n
);
  // Idle pins at time zero
  initial begin
    write_port_select_n = 1'b1;
    read_port_select_n  = 1'b1;
    addr                = '0;
    wdata               = '0;
    byte_write_mask_n   = '1;
  end

  // Write burst; go low presents the same traffic with the port deselected
  task automatic wr(input bit go, input addr_t a, input word_t [3:0] w, input mask_t [3:0] m);
    @(posedge core_clk);
    #1;
    write_port_select_n = ~go;
    addr = a;
    @(posedge core_clk);
    #1;
    write_port_select_n = 1'b1;
    addr = ~a;
    for (int i = 0; i < 2; i++) begin
      wdata = '{fall: w[2*i+1], rise: w[2*i]};
      byte_write_mask_n = '{fall: m[2*i+1], rise: m[2*i]};
      @(posedge core_clk);
      #1;
    end
    wdata = ~wdata;
    byte_write_mask_n = ~byte_write_mask_n;
  endtask

  // Read burst; collects four words and checks the enable window
  task automatic rd(input addr_t a, input bit dual, output word_t [3:0] q, output bit oe_ok);
    @(posedge core_clk);
    #1;
    read_port_select_n = 1'b0;
    addr = a;
    @(posedge core_clk);
    #1;
    read_port_select_n = 1'b1;
    addr = ~a;
    // Single mode drives words 0/1 after the next edge, dual mode one edge later
    repeat (dual ? 1 : 0) @(posedge core_clk);
    oe_ok = 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      #1;
      q[2*i] = rdata.rise;
      q[2*i+1] = rdata.fall;
      oe_ok &= (rdata_oe === 1'b1);
    end
    @(posedge core_clk);
    #1;
    oe_ok &= (rdata_oe === 1'b0);
  endtask
endmodule

// ### bench/tb_burst_sram_port.sv
// Purpose: Self-checking bench for the burst SRAM port logic
// Assumes: Fixed read latency per clock mode; store aliases above four address bits
// Notes:   Expected words come from a local merge of old data and masked new data
`timescale 1ns/1ps
module tb_burst_sram_port
  import burst_sram_pkg::*;
;
  logic       core_clk;
  logic       nrst;
  logic       single_clock_mode;
  logic       write_port_select_n;
  logic       read_port_select_n;
  addr_t      addr;
  pair_s      wdata;
  mask_pair_s byte_write_mask_n;
  pair_s      rdata;
  logic       rdata_oe;
  int         err_count;
  int         n_compared;
  int         cycles;
  word_t [3:0] w;
  word_t [3:0] q;
  word_t [3:0] exp_w;
  bit          oe_ok;

  burst_sram_port uut (.core_clk(core_clk), .nrst(nrst), .write_port_select_n(write_port_select_n),
    .read_port_select_n(read_port_select_n), .addr(addr), .wdata(wdata),
    .byte_write_mask_n(byte_write_mask_n), .single_clock_mode(single_clock_mode),
    .rdata(rdata), .rdata_oe(rdata_oe));

  sram_ctrl_model ctrl (.core_clk(core_clk), .rdata(rdata), .rdata_oe(rdata_oe),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .addr(addr), .wdata(wdata), .byte_write_mask_n(byte_write_mask_n));

  // Clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input word_t e, input word_t g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Lanes with an active-low mask bit take new data, others keep old
  function automatic word_t merge(input word_t o, input word_t n, input mask_t m);
    word_t r;
    for (int b = 0; b < 36; b++) r[b] = m[b / 9] ? o[b] : n[b];
    return r;
  endfunction

  task automatic read_back(input addr_t a, input bit dual);
    ctrl.rd(a, dual, q, oe_ok);
    for (int i = 0; i < 4; i++) chk("read word", exp_w[i], q[i]);
    chk("enable window", 36'h1, {35'h0, oe_ok});
  endtask

  // Full burst write then single clock read
  task automatic t_full();
    for (int i = 0; i < 4; i++) w[i] = 36'h123456789 + 36'(i) * 36'h111111111;
    exp_w = w;
    ctrl.wr(1'b1, 19'h3, w, '0);
    single_clock_mode = 1'b1;
    read_back(19'h3, 1'b0);
    $display("t_full done");
  endtask

  // Each beat writes one lane only, read in dual clock mode
  task automatic t_mask();
    mask_t [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m[i] = ~(4'h1 << i);
      exp_w[i] = merge(exp_w[i], ~w[i], m[i]);
    end
    ctrl.wr(1'b1, 19'h3, ~w, m);
    single_clock_mode = 1'b0;
    read_back(19'h3, 1'b1);
    $display("t_mask done");
  endtask

  // Deselected write leaves the store as it was
  task automatic t_desel();
    ctrl.wr(1'b0, 19'h3, '0, '0);
    single_clock_mode = 1'b1;
    read_back(19'h3, 1'b0);
    $display("t_desel done");
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    single_clock_mode = 1'b1;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (6) @(posedge core_clk);
    #1;
    chk("enable in reset", 36'h0, {35'h0, rdata_oe});
    nrst = 1'b1;
    repeat (4) @(posedge core_clk);
    t_full();
    t_mask();
    t_desel();
    end_sim();
  end
endmodule

// ### rtl/burst_sram_pkg.sv
// Purpose: Shared constants, types and helpers for the split port burst SRAM
// Assumes: Fixed 36-bit word configuration, four words per address
// Notes:   Store depth is trimmed to a few low address bits to stay in flip-flops
package burst_sram_pkg;

  // Word width of the configured part and lane layout
  localparam int DATA_W      = 36;
  localparam int LANE_W      = 9;
  localparam int LANES       = 4;
  localparam int NIBBLE_W    = 4;
  localparam bit NIBBLE_MODE = 1'b0;  // Only the 8-bit part uses nibble masks

  // Address width follows the word width
  function automatic int addr_width_for(input int width);
    if (width <= 9) begin
      return 21;
    end else if (width == 18) begin
      return 20;
    end else begin
      return 19;
    end
  endfunction
  localparam int ADDR_W = addr_width_for(DATA_W);  // R9

  // Four words per address, held as two pairs of two words
  localparam int WORDS_PER_ADDR = 4;
  localparam int STORE_LOC_W    = 4;
  localparam int STORE_IDX_W    = STORE_LOC_W + 1;
  localparam int STORE_PAIRS    = 1 << STORE_IDX_W;

  // Reset synchroniser value after release
  localparam logic [1:0] RST_SYNC_ON = 2'h3;

  typedef logic [DATA_W-1:0]   word_t;
  typedef logic [LANES-1:0]    mask_t;
  typedef logic [ADDR_W-1:0]   addr_t;

  // One rise beat and one fall beat of a cycle
  typedef struct packed {
    word_t fall;
    word_t rise;
  } pair_s;

  typedef struct packed {
    mask_t fall;
    mask_t rise;
  } mask_pair_s;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_BEAT01,
    PH_BEAT23
  } phase_e;

  // Expand active-low lane masks into a per-bit write enable
  function automatic word_t lane_enable(input mask_t mask_n);
    word_t en;
    en = '0;
    for (int b = 0; b < DATA_W; b++) begin
      if (NIBBLE_MODE) begin
        en[b] = ~mask_n[b / NIBBLE_W];  // R4
      end else begin
        en[b] = ~mask_n[b / LANE_W];  // R5
      end
    end
    return en;
  endfunction

endpackage

// ### rtl/burst_sram_port.sv
// Purpose: Pin-side port logic of a split read/write burst-of-four SRAM
// Assumes: core_clk rising edge stands for the positive input clock; fall beats
//          are the values sampled on the negative input clock in the same cycle
// Notes:   Read drivers are modelled as data plus output enable
// Function
// R1: Write data is captured on both input clock edges during an active write.
// R2: Write select is active low, sampled on positive clock; low starts a write.
// R3: Write select high deselects the write port and ignores write data.
// R4: In 8-bit parts two nibble masks gate bits [3:0] and [7:4].
// R5: In wider parts each byte mask gates one 9-bit lane.
// R6: A lane with its mask deasserted keeps memory contents; its data is dropped.
// R7: Masks are sampled on the same edge as their data beat.
// R8: One shared address bus is sampled on the positive clock for both ports.
// R9: Address width is 21, 20 or 19 bits by configuration.
// R10: Address is ignored for a port whose select is deasserted.
// R11: Read data leaves on both output clock edges, or input clocks in single mode.
// R12: Read outputs go high-impedance when the read port is deselected.
// R13: Each address selects four words held in four equal internal arrays; here one store holds them as two pairs per address.
// R14: Read select is active low; a sampled low starts a four-word read burst.
// R15: On deselect the pending read completes, then drivers turn off.
// R16: Controller gives four write beats on the two cycles after the request.
// R17: Burst words go in sequential order, no wrap, same for both ports.
`timescale 1ns/1ps
module burst_sram_port
  import burst_sram_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       write_port_select_n,
  input  wire logic       read_port_select_n,
  input  wire addr_t      addr,
  input  wire pair_s      wdata,
  input  wire mask_pair_s byte_write_mask_n,
  input  wire logic       single_clock_mode,
  output pair_s           rdata,
  output logic            rdata_oe
);

  typedef struct packed {
    phase_e     wph;
    addr_t      waddr;
    logic       wr_en;
    logic [STORE_IDX_W-1:0] wr_idx;
    pair_s      wd;
    mask_pair_s wm;
    phase_e     rph;
    addr_t      raddr;
    logic       p_valid;
    pair_s      p;
    logic       o_valid;
    pair_s      q;
  } state_s;

  logic [1:0]             rst_sync;
  logic                   rst_n;
  state_s                 s;
  state_s                 next_s;
  pair_s                  rd_pair;
  logic [STORE_IDX_W-1:0] rd_idx;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= '0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  // Only the second flop is read, so release reaches the design on the second edge
  assign rst_n = rst_sync[1];

  // Pair 0 holds words 0 and 1, pair 1 words 2 and 3
  assign rd_idx = {s.raddr[STORE_LOC_W-1:0], s.rph == PH_BEAT23};  // R13 R17

  burst_sram_store u_store (
    .core_clk  (core_clk),
    .wr_en     (s.wr_en),
    .wr_idx    (s.wr_idx),
    .wr_pair   (s.wd),
    .wr_mask_n (s.wm),
    .rd_idx    (rd_idx),
    .rd_pair   (rd_pair)
  );

  // Next state of both ports
  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    // Write port: request, then two cycles of rise/fall beats
    case (s.wph)
      PH_BEAT01: begin
        next_s.wph    = PH_BEAT23;
        next_s.wr_en  = 1'b1;  // R1
        next_s.wr_idx = {s.waddr[STORE_LOC_W-1:0], 1'b0};  // R17
        next_s.wd     = wdata;  // R1
        next_s.wm     = byte_write_mask_n;  // R7
      end
      PH_BEAT23: begin
        next_s.wph    = PH_IDLE;
        next_s.wr_en  = 1'b1;
        next_s.wr_idx = {s.waddr[STORE_LOC_W-1:0], 1'b1};  // R17
        next_s.wd     = wdata;
        next_s.wm     = byte_write_mask_n;  // R7
      end
      default: begin
        next_s.wph = PH_IDLE;
      end
    endcase
    if (s.wph != PH_BEAT01 && !write_port_select_n) begin
      next_s.wph   = PH_BEAT01;  // R2
      next_s.waddr = addr;  // R8
    end
    // With the select high, address is left unused and data only fill a burst already started R3 R10
    // Read port: two pairs leave after the request
    case (s.rph)
      PH_BEAT01: begin
        next_s.rph = PH_BEAT23;
      end
      default: begin
        next_s.rph = PH_IDLE;
      end
    endcase
    if (s.rph != PH_BEAT01 && !read_port_select_n) begin
      next_s.rph   = PH_BEAT01;  // R14
      next_s.raddr = addr;  // R8 R10
    end
    next_s.p_valid = (s.rph != PH_IDLE);
    next_s.p       = rd_pair;
    // Single clock mode skips the output clock stage
    if (single_clock_mode) begin
      next_s.o_valid = next_s.p_valid;  // R11
      next_s.q       = next_s.p;
    end else begin
      next_s.o_valid = s.p_valid;  // R11
      next_s.q       = s.p;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.wph <= PH_IDLE;
      s.rph <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Drivers on only while burst beats are out
  assign rdata    = s.q;  // R11
  assign rdata_oe = s.o_valid;  // R12 R15

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence write_req;
    !write_port_select_n && s.wph != PH_BEAT01;
  endsequence

  sequence read_req;
    !read_port_select_n && s.rph != PH_BEAT01;
  endsequence

  a_write_start: assert property (write_req |=> s.wph == PH_BEAT01 && s.waddr == $past(addr)) // R2
    else $error("Write request not started");

  a_write_beats: assert property (write_req |=> ##1 s.wr_en && s.wr_idx[0] == 1'b0 ##1 s.wr_en && s.wr_idx[0]) // R1
    else $error("Write beats not stored in order");

  a_mask_same_edge: assert property (s.wph == PH_BEAT01 |=> s.wm == $past(byte_write_mask_n) // R7
                                     && s.wd == $past(wdata))
    else $error("Mask not sampled with its data");

  a_write_idle: assert property (write_port_select_n && s.wph != PH_BEAT01 |=> s.wph == PH_IDLE) // R3
    else $error("Write port active while deselected");

  a_addr_ignored: assert property (read_port_select_n && s.rph != PH_BEAT01 |=> $stable(s.raddr)) // R10
    else $error("Read address taken while deselected");

  // Single mode: drivers on for the two cycles after the edge that follows the request
  a_read_single: assert property ((read_req and single_clock_mode) ##1 single_clock_mode |=> rdata_oe[*2]) // R11
    else $error("Single clock read burst not driven");

  // Dual mode: the output stage adds one cycle before the two driven cycles
  a_read_dual: assert property ((read_req and !single_clock_mode) ##1 !single_clock_mode[*3] // R14
                                |=> rdata_oe && $past(rdata_oe))
    else $error("Read burst not driven");

  a_drive_off: assert property (s.rph == PH_IDLE && !s.p_valid && !s.o_valid |=> !rdata_oe) // R12
    else $error("Drivers on without a pending read");

  a_read_order: assert property (s.rph == PH_BEAT01 |=> s.rph == PH_BEAT23 && rd_idx[0]) // R17
    else $error("Read burst out of order");

  a_pending_done: assert property (s.p_valid && single_clock_mode |-> ##0 rdata_oe) // R15
    else $error("Pending read dropped");

endmodule

// ### rtl/burst_sram_store.sv
// Purpose: Flip-flop word store, two words per entry, masked lane writes
// Assumes: One write pair and one read pair per clock
// Notes:   Read is combinational; the caller registers it
`timescale 1ns/1ps
module burst_sram_store
  import burst_sram_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   wr_en,
  input  wire logic [STORE_IDX_W-1:0] wr_idx,
  input  wire pair_s                  wr_pair,
  input  wire mask_pair_s             wr_mask_n,
  input  wire logic [STORE_IDX_W-1:0] rd_idx,
  output pair_s                       rd_pair
);

  pair_s mem [STORE_PAIRS];

  // Lanes with a deasserted mask keep their old contents
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx].rise <= (mem[wr_idx].rise & ~lane_enable(wr_mask_n.rise))
                        | (wr_pair.rise & lane_enable(wr_mask_n.rise));  // R6
      mem[wr_idx].fall <= (mem[wr_idx].fall & ~lane_enable(wr_mask_n.fall))
                        | (wr_pair.fall & lane_enable(wr_mask_n.fall));  // R6
    end
  end

  // Read the addressed pair
  assign rd_pair = mem[rd_idx];

endmodule
